/* File: bst_pkg.sv */
package bsp_pkg;

  // ***************************************************************
  // sizes and opcodes
  // ***************************************************************
  localparam int unsigned IR_LEN     = 4;
  localparam int unsigned NUM_IN     = 8;
  localparam int unsigned NUM_OUT    = 8;
  localparam int unsigned SIG_LEN    = 32;
  localparam int unsigned ID_LEN     = 32;
  localparam int unsigned CFG_W      = 8;

  localparam logic [3:0]  OP_EXTEST  = 4'h0;
  localparam logic [3:0]  OP_SAMPLE  = 4'h1;
  localparam logic [3:0]  OP_IDCODE  = 4'h6;
  localparam logic [3:0]  OP_USERSIG = 4'h7;
  localparam logic [3:0]  OP_RECONFIG = 4'h8;
  localparam logic [3:0]  OP_BYPASS  = 4'hF;

  // ***************************************************************
  // capture and reset values
  // ***************************************************************
  localparam logic [3:0]  IR_CAPTURE = 4'h1;
  // arbitrary identification value, bit 0 set as the scan standard asks
  localparam logic [31:0] ID_VALUE   = 32'h0A5C_3001;
  localparam logic        TDO_RESET  = 1'b0;

  // ***************************************************************
  // types
  // ***************************************************************
  typedef enum logic [3:0] {
    ST_RESET  = 4'b0000, ST_IDLE   = 4'b0001, ST_SEL_DR = 4'b0011,
    ST_CAP_DR = 4'b0010, ST_SH_DR  = 4'b0110, ST_EX1_DR = 4'b0111,
    ST_PA_DR  = 4'b0101, ST_EX2_DR = 4'b0100, ST_UPD_DR = 4'b1100,
    ST_SEL_IR = 4'b1101, ST_CAP_IR = 4'b1111, ST_SH_IR  = 4'b1110,
    ST_EX1_IR = 4'b1010, ST_PA_IR  = 4'b1011, ST_EX2_IR = 4'b1001,
    ST_UPD_IR = 4'b1000
  } bsp_state_type;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } bsp_jtag_type;

  typedef struct packed {
    logic             stb;
    logic [CFG_W-1:0] data;
  } bsp_cfg_type;

endpackage

/* File: bst_sync.sv */
`timescale 1ns/1ps
module bsp_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  // ***************************************************************
  // two-stage synchroniser
  // ***************************************************************
  logic [W-1:0] meta;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= '0;
      q_o  <= '0;
    end else if (ce_i) begin
      meta <= d_i;
      q_o  <= meta;
    end
  end

endmodule

/* File: bst_tap.sv */
`timescale 1ns/1ps
module bsp_tap
  import bsp_pkg::*;
#(
  parameter int unsigned     N_IN       = bsp_pkg::NUM_IN,
  parameter int unsigned     N_OUT      = bsp_pkg::NUM_OUT,
  parameter int unsigned     IR_W       = bsp_pkg::IR_LEN,
  parameter logic [31:0]     ID_CODE    = bsp_pkg::ID_VALUE,
  parameter logic [IR_W-1:0] C_EXTEST   = bsp_pkg::OP_EXTEST,
  parameter logic [IR_W-1:0] C_SAMPLE   = bsp_pkg::OP_SAMPLE,
  parameter logic [IR_W-1:0] C_IDCODE   = bsp_pkg::OP_IDCODE,
  parameter logic [IR_W-1:0] C_USERSIG  = bsp_pkg::OP_USERSIG,
  parameter logic [IR_W-1:0] C_RECONFIG = bsp_pkg::OP_RECONFIG,
  parameter logic [IR_W-1:0] C_BYPASS   = bsp_pkg::OP_BYPASS
) (
  input  wire logic                      MCLK_I,
  input  wire logic                      RST_I,
  input  wire logic                      CE_I,
  input  wire bsp_pkg::bsp_jtag_type     JTAG_I,
  output logic                           TDO_O,
  output logic                           TDO_OE_O,
  input  wire logic [N_IN-1:0]           PIN_I,
  output logic      [N_IN-1:0]           CORE_IN_O,
  input  wire logic [N_OUT-1:0]          CORE_OUT_I,
  output logic      [N_OUT-1:0]          PIN_O,
  input  wire logic                      CFG_BUSY_I,
  input  wire logic [bsp_pkg::SIG_LEN-1:0] USER_SIG_I,
  output logic                           CFG_MODE_O,
  output bsp_pkg::bsp_cfg_type           CFG_O
);

  localparam int unsigned BSR_LEN = N_IN + N_OUT;

  // ***************************************************************
  // pin synchronisers
  // ***************************************************************
  bsp_jtag_type    jtag_s;
  logic [N_IN-1:0] pin_s;
  logic            tck_d;
  logic            next_tck_d;
  logic            rise;
  logic            fall;

  bsp_sync #(.W(3)) u_sync_jtag (
    .clk_i (MCLK_I),
    .rst_i (RST_I),
    .ce_i  (CE_I),
    .d_i   (JTAG_I),
    .q_o   (jtag_s)
  );

  bsp_sync #(.W(N_IN)) u_sync_pin (
    .clk_i (MCLK_I),
    .rst_i (RST_I),
    .ce_i  (CE_I),
    .d_i   (PIN_I),
    .q_o   (pin_s)
  );

  assign rise = jtag_s.tck & ~tck_d;
  assign fall = ~jtag_s.tck & tck_d;

  // ***************************************************************
  // tck edge detect
  // ***************************************************************
  always_comb begin
    next_tck_d = jtag_s.tck;
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      tck_d <= 1'b0;
    end else if (CE_I) begin
      tck_d <= next_tck_d;
    end
  end

  // ***************************************************************
  // state
  // ***************************************************************
  bsp_state_type          state,    next_state;
  logic [IR_W-1:0]        ir,       next_ir;
  logic [IR_W-1:0]        ir_sh,    next_ir_sh;
  logic                   byp,      next_byp;
  logic [ID_LEN-1:0]      id_sh,    next_id_sh;
  logic [SIG_LEN-1:0]     sig_sh,   next_sig_sh;
  logic [BSR_LEN-1:0]     bsr_sh,   next_bsr_sh;
  logic [N_OUT-1:0]       bsr_upd,  next_bsr_upd;
  logic [CFG_W-1:0]       cfg_sh,   next_cfg_sh;
  logic [2:0]             cfg_cnt,  next_cfg_cnt;
  logic                   tdo,      next_tdo;
  logic                   tdo_oe,   next_tdo_oe;
  logic [N_IN-1:0]        core_in,  next_core_in;
  logic [N_OUT-1:0]       pin_out,  next_pin_out;
  logic                   cfg_mode, next_cfg_mode;
  bsp_cfg_type            cfg,      next_cfg;
  logic [IR_W-1:0]        eff;

  // ***************************************************************
  // effective instruction
  // ***************************************************************
  always_comb begin
    eff = ir;
    if (CFG_BUSY_I && (ir == C_EXTEST || ir == C_SAMPLE)) begin
      eff = C_BYPASS;
    end else if (ir != C_EXTEST && ir != C_SAMPLE && ir != C_IDCODE &&
                 ir != C_USERSIG && ir != C_RECONFIG) begin
      eff = C_BYPASS;
    end
  end

  // ***************************************************************
  // controller next values
  // ***************************************************************
  always_comb begin
    next_state    = state;
    next_ir       = ir;
    next_ir_sh    = ir_sh;
    next_byp      = byp;
    next_id_sh    = id_sh;
    next_sig_sh   = sig_sh;
    next_bsr_sh   = bsr_sh;
    next_bsr_upd  = bsr_upd;
    next_cfg_sh   = cfg_sh;
    next_cfg_cnt  = cfg_cnt;
    next_tdo      = tdo;
    next_tdo_oe   = tdo_oe;
    next_cfg      = '0;

    if (rise) begin
      unique case (state)
        ST_RESET:  next_state = jtag_s.tms ? ST_RESET  : ST_IDLE;
        ST_IDLE:   next_state = jtag_s.tms ? ST_SEL_DR : ST_IDLE;
        ST_SEL_DR: next_state = jtag_s.tms ? ST_SEL_IR : ST_CAP_DR;
        ST_CAP_DR: next_state = jtag_s.tms ? ST_EX1_DR : ST_SH_DR;
        ST_SH_DR:  next_state = jtag_s.tms ? ST_EX1_DR : ST_SH_DR;
        ST_EX1_DR: next_state = jtag_s.tms ? ST_UPD_DR : ST_PA_DR;
        ST_PA_DR:  next_state = jtag_s.tms ? ST_EX2_DR : ST_PA_DR;
        ST_EX2_DR: next_state = jtag_s.tms ? ST_UPD_DR : ST_SH_DR;
        ST_UPD_DR: next_state = jtag_s.tms ? ST_SEL_DR : ST_IDLE;
        ST_SEL_IR: next_state = jtag_s.tms ? ST_RESET  : ST_CAP_IR;
        ST_CAP_IR: next_state = jtag_s.tms ? ST_EX1_IR : ST_SH_IR;
        ST_SH_IR:  next_state = jtag_s.tms ? ST_EX1_IR : ST_SH_IR;
        ST_EX1_IR: next_state = jtag_s.tms ? ST_UPD_IR : ST_PA_IR;
        ST_PA_IR:  next_state = jtag_s.tms ? ST_EX2_IR : ST_PA_IR;
        ST_EX2_IR: next_state = jtag_s.tms ? ST_UPD_IR : ST_SH_IR;
        ST_UPD_IR: next_state = jtag_s.tms ? ST_SEL_DR : ST_IDLE;
      endcase

      unique case (state)
        ST_CAP_IR: begin
          next_ir_sh = IR_W'(IR_CAPTURE);
        end
        ST_SH_IR: begin
          next_ir_sh = {jtag_s.tdi, ir_sh[IR_W-1:1]};
        end
        ST_CAP_DR: begin
          next_byp     = 1'b0;
          next_id_sh   = ID_CODE;
          next_sig_sh  = USER_SIG_I;
          next_cfg_cnt = '0;
          if (eff == C_SAMPLE || eff == C_EXTEST) begin
            next_bsr_sh = {CORE_OUT_I, pin_s};
          end
        end
        ST_SH_DR: begin
          if (eff == C_IDCODE) begin
            next_id_sh = {jtag_s.tdi, id_sh[ID_LEN-1:1]};
          end else if (eff == C_USERSIG) begin
            next_sig_sh = {jtag_s.tdi, sig_sh[SIG_LEN-1:1]};
          end else if (eff == C_SAMPLE || eff == C_EXTEST) begin
            next_bsr_sh = {jtag_s.tdi, bsr_sh[BSR_LEN-1:1]};
          end else if (eff == C_RECONFIG) begin
            next_cfg_sh  = {jtag_s.tdi, cfg_sh[CFG_W-1:1]};
            next_cfg_cnt = cfg_cnt + 3'd1;
            if (cfg_cnt == 3'd7) begin
              next_cfg.stb  = 1'b1;
              next_cfg.data = {jtag_s.tdi, cfg_sh[CFG_W-1:1]};
            end
          end else begin
            next_byp = jtag_s.tdi;
          end
        end
        default: begin
        end
      endcase
    end

    if (fall) begin
      next_tdo_oe = (state == ST_SH_DR) || (state == ST_SH_IR);
      if (state == ST_SH_IR) begin
        next_tdo = ir_sh[0];
      end else if (state == ST_SH_DR) begin
        if (eff == C_IDCODE) begin
          next_tdo = id_sh[0];
        end else if (eff == C_USERSIG) begin
          next_tdo = sig_sh[0];
        end else if (eff == C_SAMPLE || eff == C_EXTEST) begin
          next_tdo = bsr_sh[0];
        end else if (eff == C_RECONFIG) begin
          next_tdo = 1'b0;
        end else begin
          next_tdo = byp;
        end
      end
      if (state == ST_RESET) begin
        next_ir = C_IDCODE;
      end
      if (state == ST_UPD_IR) begin
        next_ir = ir_sh;
      end
      if (state == ST_UPD_DR && (eff == C_SAMPLE || eff == C_EXTEST)) begin
        next_bsr_upd = bsr_sh[BSR_LEN-1:N_IN];
      end
    end
  end

  // ***************************************************************
  // controller registers
  // ***************************************************************
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      state    <= ST_RESET;
      ir       <= C_IDCODE;
      ir_sh    <= '0;
      byp      <= 1'b0;
      id_sh    <= '0;
      sig_sh   <= '0;
      bsr_sh   <= '0;
      bsr_upd  <= '0;
      cfg_sh   <= '0;
      cfg_cnt  <= '0;
      tdo      <= TDO_RESET;
      tdo_oe   <= 1'b0;
      cfg      <= '0;
    end else if (CE_I) begin
      state    <= next_state;
      ir       <= next_ir;
      ir_sh    <= next_ir_sh;
      byp      <= next_byp;
      id_sh    <= next_id_sh;
      sig_sh   <= next_sig_sh;
      bsr_sh   <= next_bsr_sh;
      bsr_upd  <= next_bsr_upd;
      cfg_sh   <= next_cfg_sh;
      cfg_cnt  <= next_cfg_cnt;
      tdo      <= next_tdo;
      tdo_oe   <= next_tdo_oe;
      cfg      <= next_cfg;
    end
  end

  // ***************************************************************
  // pin path next values
  // ***************************************************************
  always_comb begin
    next_core_in  = pin_s;
    next_cfg_mode = (eff == C_RECONFIG);
    if (eff == C_EXTEST) begin
      next_pin_out = bsr_upd;
    end else begin
      next_pin_out = CORE_OUT_I;
    end
  end

  // ***************************************************************
  // pin path registers
  // ***************************************************************
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      core_in  <= '0;
      pin_out  <= '0;
      cfg_mode <= 1'b0;
    end else if (CE_I) begin
      core_in  <= next_core_in;
      pin_out  <= next_pin_out;
      cfg_mode <= next_cfg_mode;
    end
  end

  // ***************************************************************
  // outputs
  // ***************************************************************
  assign TDO_O      = tdo;
  assign TDO_OE_O   = tdo_oe;
  assign CORE_IN_O  = core_in;
  assign PIN_O      = pin_out;
  assign CFG_MODE_O = cfg_mode;
  assign CFG_O      = cfg;

endmodule

/* File: bst_tap_props.sv */
`timescale 1ns/1ps
module bsp_tap_props
  import bsp_pkg::*;
#(
  parameter int unsigned N_IN  = 8,
  parameter int unsigned N_OUT = 8
) (
  input wire logic                 MCLK_I,
  input wire logic                 RST_I,
  input wire logic                 CE_I,
  input wire bsp_pkg::bsp_jtag_type JTAG_I,
  input wire logic                 TDO_O,
  input wire logic                 TDO_OE_O,
  input wire logic [N_IN-1:0]      PIN_I,
  input wire logic [N_IN-1:0]      CORE_IN_O,
  input wire logic [N_OUT-1:0]     CORE_OUT_I,
  input wire logic [N_OUT-1:0]     PIN_O,
  input wire logic                 CFG_BUSY_I,
  input wire logic                 CFG_MODE_O,
  input wire bsp_pkg::bsp_cfg_type CFG_O
);
  // ***
  // scan port checks
  // ***
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (RST_I);
  sequence s_pin_quiet;
    (CE_I && $stable(PIN_I))[*5];
  endsequence
  sequence s_busy_quiet;
    (CE_I && CFG_BUSY_I && $stable(CORE_OUT_I))[*4];
  endsequence
  property p_reset_quiet;
    $fell(RST_I) |-> !TDO_O && !TDO_OE_O && PIN_O == '0 && !CFG_MODE_O && !CFG_O.stb;
  endproperty
  property p_tdo_fall;
    $changed(TDO_O) && !$past(RST_I) |-> !$past(JTAG_I.tck, 3) || !$past(JTAG_I.tck, 4);
  endproperty
  property p_oe_fall;
    $changed(TDO_OE_O) && !$past(RST_I) |-> !$past(JTAG_I.tck, 3) || !$past(JTAG_I.tck, 4);
  endproperty
  property p_mode_fall;
    $changed(CFG_MODE_O) && !$past(RST_I) |-> !$past(JTAG_I.tck, 3) || !$past(JTAG_I.tck, 4);
  endproperty
  property p_stb_pulse;
    CFG_O.stb && CE_I |=> !CFG_O.stb;
  endproperty
  property p_stb_mode;
    CFG_O.stb |-> CFG_MODE_O;
  endproperty
  property p_core_pass;
    s_pin_quiet |-> CORE_IN_O == PIN_I;
  endproperty
  property p_busy_pins;
    s_busy_quiet |-> PIN_O == CORE_OUT_I;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("outputs not idle after reset");
  a_tdo_fall: assert property (p_tdo_fall)
    else $error("serial out moved without falling tck");
  a_oe_fall: assert property (p_oe_fall)
    else $error("out enable moved without falling tck");
  a_mode_fall: assert property (p_mode_fall)
    else $error("reconfig mode moved without falling tck");
  a_stb_pulse: assert property (p_stb_pulse)
    else $error("byte strobe longer than one cycle");
  a_stb_mode: assert property (p_stb_mode)
    else $error("byte strobe outside reconfig mode");
  a_core_pass: assert property (p_core_pass)
    else $error("core input disturbed");
  a_busy_pins: assert property (p_busy_pins)
    else $error("pins not from core while configuring");
endmodule

/* File: bst_host.sv */
`timescale 1ns/1ps
module bsp_host
  import bsp_pkg::*;
(
  output bsp_pkg::bsp_jtag_type jtag_o,
  input  wire logic             tdo_i
);
  // ***
  // scan controller, tck still between steps
  // ***
  initial jtag_o = '0;
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    jtag_o.tms = tms;
    jtag_o.tdi = tdi;
    #100;
    tdo = tdo_i;
    jtag_o.tck = 1'b1;
    #60;
    jtag_o.tck = 1'b0;
  endtask
  // idle to shift, n bits lsb first, back to idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic t;
    dout = '0;
    step(1'b1, 1'b0, t);
    if (ir) step(1'b1, 1'b0, t);
    step(1'b0, 1'b0, t);
    step(1'b0, 1'b0, t);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], t);
      dout[i] = t;
    end
    step(1'b1, 1'b0, t);
    step(1'b0, 1'b0, t);
  endtask
endmodule

/* File: bst_tb.sv */
`timescale 1ns/1ps
module testbench;
  import bsp_pkg::*;
  logic         MCLK_I, RST_I, CE_I, CFG_BUSY_I, TDO_O, TDO_OE_O, CFG_MODE_O;
  logic [7:0]   PIN_I, CORE_OUT_I, CORE_IN_O, PIN_O;
  logic [31:0]  USER_SIG_I, q;
  bsp_jtag_type JTAG_I;
  bsp_cfg_type  CFG_O;
  logic [7:0]   bytes[$];
  int           num_errors = 0;
  int           num_checks = 0;
  bsp_tap dut (.MCLK_I(MCLK_I), .RST_I(RST_I), .CE_I(CE_I), .JTAG_I(JTAG_I),
    .TDO_O(TDO_O), .TDO_OE_O(TDO_OE_O), .PIN_I(PIN_I), .CORE_IN_O(CORE_IN_O),
    .CORE_OUT_I(CORE_OUT_I), .PIN_O(PIN_O), .CFG_BUSY_I(CFG_BUSY_I),
    .USER_SIG_I(USER_SIG_I), .CFG_MODE_O(CFG_MODE_O), .CFG_O(CFG_O));
  // released serial line floats high through its pull-up
  bsp_host host (.jtag_o(JTAG_I), .tdo_i(TDO_OE_O ? TDO_O : 1'b1));
  initial begin
    MCLK_I = 1'b0;
    forever #10 MCLK_I = ~MCLK_I;
  end
  always @(negedge MCLK_I) if (CFG_O.stb === 1'b1) bytes.push_back(CFG_O.data);
  // ***
  // helpers
  // ***
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(negedge MCLK_I);
  endtask
  task automatic load_ir(input logic [3:0] op);
    host.scan(1'b1, 4, {28'h0, op}, q);
    wait_clk(8);
  endtask
  task automatic do_reset;
    RST_I = 1'b1;
    wait_clk(16);
    check("pins in reset", 32'h0, {24'h0, PIN_O});
    RST_I = 1'b0;
    wait_clk(4);
    host.step(1'b0, 1'b0, q[0]);
  endtask
  // ***
  // scenarios
  // ***
  task automatic t_id;
    host.scan(1'b0, 32, 32'h0, q);
    check("idcode", ID_VALUE, q);
    $display("idcode test done");
  endtask
  task automatic t_sig;
    load_ir(OP_USERSIG);
    host.scan(1'b0, 32, 32'h0, q);
    check("user signature", USER_SIG_I, q);
    $display("signature test done");
  endtask
  task automatic t_bypass;
    logic [3:0] ops[2];
    ops = '{OP_BYPASS, 4'h3};
    foreach (ops[i]) begin
      load_ir(ops[i]);
      host.scan(1'b0, 8, 32'hA5, q);
      check("bypass", 32'h4A, q);
    end
    $display("bypass test done");
  endtask
  task automatic t_boundary;
    PIN_I = 8'h3C;
    load_ir(OP_SAMPLE);
    host.scan(1'b0, 16, 32'h5AC3, q);
    check("sample", 32'h963C, q);
    check("pins under sample", 32'h96, {24'h0, PIN_O});
    load_ir(OP_EXTEST);
    check("preload", 32'h5A, {24'h0, PIN_O});
    PIN_I = 8'hE1;
    host.scan(1'b0, 16, 32'h7100, q);
    check("extest capture", 32'hE1, {24'h0, q[7:0]});
    wait_clk(8);
    check("extest pins", 32'h71, {24'h0, PIN_O});
    check("core in", 32'hE1, {24'h0, CORE_IN_O});
    CFG_BUSY_I = 1'b1;
    wait_clk(8);
    check("pins while busy", 32'h96, {24'h0, PIN_O});
    host.scan(1'b0, 8, 32'hA5, q);
    check("busy bypass", 32'h4A, q);
    CFG_BUSY_I = 1'b0;
    wait_clk(8);
    check("pins after busy", 32'h71, {24'h0, PIN_O});
    $display("boundary test done");
  endtask
  task automatic t_freeze;
    CE_I = 1'b0;
    PIN_I = 8'h5A;
    wait_clk(8);
    check("frozen core in", 32'hE1, {24'h0, CORE_IN_O});
    CE_I = 1'b1;
    wait_clk(8);
    check("core in resumed", 32'h5A, {24'h0, CORE_IN_O});
    $display("freeze test done");
  endtask
  task automatic t_reconfig;
    load_ir(OP_RECONFIG);
    check("reconfig mode", 32'h1, {31'h0, CFG_MODE_O});
    bytes.delete();
    host.scan(1'b0, 12, 32'hB69, q);
    check("byte count", 32'h1, 32'(bytes.size()));
    check("byte", 32'h69, {24'h0, bytes[0]});
    load_ir(OP_BYPASS);
    check("mode off", 32'h0, {31'h0, CFG_MODE_O});
    $display("reconfig test done");
  endtask
  task automatic end_of_test;
    $display("checks %0d, errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    RST_I = 1'b1;
    CFG_BUSY_I = 1'b0;
    PIN_I = 8'h00;
    CE_I = 1'b1;
    CORE_OUT_I = 8'h96;
    USER_SIG_I = 32'h1234_ABCD;
    do_reset();
    t_id();
    t_sig();
    t_bypass();
    t_boundary();
    t_freeze();
    t_reconfig();
    do_reset();
    t_id();
    end_of_test();
  end
endmodule

bind bsp_tap bsp_tap_props #(.N_IN(N_IN), .N_OUT(N_OUT)) u_props (.MCLK_I(MCLK_I),
  .RST_I(RST_I), .CE_I(CE_I), .JTAG_I(JTAG_I), .TDO_O(TDO_O), .TDO_OE_O(TDO_OE_O),
  .PIN_I(PIN_I), .CORE_IN_O(CORE_IN_O), .CORE_OUT_I(CORE_OUT_I), .PIN_O(PIN_O),
  .CFG_BUSY_I(CFG_BUSY_I), .CFG_MODE_O(CFG_MODE_O), .CFG_O(CFG_O));
